// file: crr_reply_regs.sv
// Cyclic reply register map returned from the drive to the network master
//
// Added by the designer: strobed register access and the register addresses.
`include "crr_params.svh"

module crr_reply_regs (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   // Cyclic exchange
   input  wire logic               cyc_tick,
   input  wire crr_pkg::crr_word_t layout_select_param,
   input  wire logic               monitor_request_bit,
   input  wire logic               freq_write_ram_strobe,
   input  wire logic               freq_write_eeprom_strobe,
   input  wire logic               instruction_execute_bit,
   input  wire crr_pkg::crr_word_t monitor_code_word,
   input  wire crr_pkg::crr_word_t monitor_code_word_4,
   input  wire crr_pkg::crr_word_t monitor_code_word_5,
   input  wire crr_pkg::crr_word_t monitor_code_word_6,
   input  wire crr_pkg::crr_word_t monitor_code_word_7,
   input  wire crr_pkg::crr_word_t fault_record_select_word,
   output logic                    instruction_done_flag,
   // Drive core status
   input  wire crr_pkg::crr_word_t out_freq,
   input  wire logic               negative_display_param,
   input  wire logic               mon_wr,
   input  wire crr_pkg::crr_byte_t mon_wr_item,
   input  wire crr_pkg::crr_word_t mon_wr_value,
   input  wire logic               flt_wr,
   input  wire crr_pkg::crr_byte_t flt_wr_code,
   input  wire crr_pkg::crr_word_t flt_wr_freq,
   input  wire crr_pkg::crr_word_t flt_wr_cur,
   input  wire crr_pkg::crr_word_t flt_wr_volt,
   input  wire crr_pkg::crr_word_t flt_wr_time,
   // Drive core command handshakes
   output logic                    freq_start,
   input  wire logic               freq_done,
   input  wire crr_pkg::crr_byte_t freq_reply_code,
   output logic                    instr_start,
   input  wire logic               instr_done,
   input  wire crr_pkg::crr_byte_t instr_reply_code,
   input  wire crr_pkg::crr_word_t instr_read_data,
   input  wire logic [79:0]        slot_reply_codes,
   input  wire logic [79:0]        slot_read_data,
   // Register port
   input  wire crr_pkg::crr_addr_t reg_addr,
   input  wire logic               reg_wr,
   input  wire crr_pkg::crr_word_t reg_wr_data,
   input  wire logic               reg_rd,
   output crr_pkg::crr_word_t      reg_rd_data,
   output logic                    irq
);
   import crr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Storage

   crr_word_t        mon_tab [0:255];
   crr_byte_t        flt_code_tab [0:`CRR_FLT_DEPTH-1];
   crr_word_t        flt_freq_tab [0:`CRR_FLT_DEPTH-1];
   crr_word_t        flt_cur_tab  [0:`CRR_FLT_DEPTH-1];
   crr_word_t        flt_volt_tab [0:`CRR_FLT_DEPTH-1];
   crr_word_t        flt_time_tab [0:`CRR_FLT_DEPTH-1];
   logic [2:0]       flt_wp_q;
   logic [7:0]       flt_vld_q;
   logic [255:0]     mon_vld_q;
   crr_byte_t        mon_sel [0:5];
   crr_word_t        mon_val [0:5];
   crr_word_t        rep_q [0:`CRR_NUM_WORDS-1];
   crr_word_t        live_w [0:`CRR_NUM_WORDS-1];
   crr_byte_t        freq_reply_q;
   crr_byte_t        instr_reply_q;
   crr_word_t        instr_data_q;
   logic [79:0]      slot_reply_q;
   logic [79:0]      slot_data_q;
   crr_instr_state_t st_q;
   crr_instr_state_t st_d;
   logic             exec_prev_q;
   logic             fstb_prev_q;
   logic [2:0]       mask_q;
   logic [2:0]       stat_q;
   logic [2:0]       stat_d;

   ////////////////////////////////////////////////////////////////////////
   // Decode

   wire layout_ok = (layout_select_param == `CRR_LAYOUT_A) ||
                    (layout_select_param == `CRR_LAYOUT_B) ||
                    (layout_select_param == `CRR_LAYOUT_C) ||
                    (layout_select_param == `CRR_LAYOUT_D) ||
                    (layout_select_param == `CRR_LAYOUT_E);
   wire fstb      = freq_write_ram_strobe | freq_write_eeprom_strobe;
   wire fstb_rise = fstb & ~fstb_prev_q;
   wire exec_rise = instruction_execute_bit & ~exec_prev_q;
   wire rd_word   = reg_addr <= `CRR_W_LAST;
   wire rd_mask   = reg_addr == `CRR_A_IRQ_MASK;
   wire rd_stat   = reg_addr == `CRR_A_IRQ_STAT;
   wire wr_mask   = reg_wr & rd_mask;
   wire clr_stat  = reg_rd & rd_stat;

   // Sign handling for monitor items; the setting is an argument so that
   // a change of it alone re-evaluates every caller
   function automatic crr_word_t disp(input crr_word_t v, input logic neg);
      disp = (v[15] && !neg) ? 16'h0000 - v : v;
   endfunction

   wire crr_byte_t code_lo   = monitor_code_word[7:0];
   wire crr_byte_t code_hi   = monitor_code_word[15:8];
   wire crr_byte_t flt_no    = fault_record_select_word[7:0];
   // Record 0 is the newest; numbers past the depth read as zero
   wire [2:0]      flt_idx   = flt_wp_q - 3'h1 - flt_no[2:0];
   // Slots never written also read as zero, not as stale memory
   wire            flt_hit   = (flt_no < 8'(`CRR_FLT_DEPTH)) &&
                               flt_vld_q[flt_idx];
   wire crr_byte_t flt_code  = flt_hit ? flt_code_tab[flt_idx] : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Live reply values

   genvar g;

   // Monitor items are stored raw by the core, so frequency class items
   // never pass through any speed display scaling here; items the core
   // never wrote read as zero
   assign mon_sel[0] = code_lo;
   assign mon_sel[1] = code_hi;
   assign mon_sel[2] = monitor_code_word_4[7:0];
   assign mon_sel[3] = monitor_code_word_5[7:0];
   assign mon_sel[4] = monitor_code_word_6[7:0];
   assign mon_sel[5] = monitor_code_word_7[7:0];
   generate
      for (g = 0; g < 6; g++) begin : g_mon
         assign mon_val[g] = disp(mon_vld_q[mon_sel[g]] ?
                                  mon_tab[mon_sel[g]] : 16'h0000,
                                  negative_display_param);
      end
   endgenerate

   assign live_w[`CRR_W_MON1] = monitor_request_bit ? mon_val[0] :
                                rep_q[`CRR_W_MON1];
   assign live_w[`CRR_W_MON2] = (code_hi == 8'h00) ?
                                disp(out_freq, negative_display_param) :
                                monitor_request_bit ? mon_val[1] :
                                rep_q[`CRR_W_MON2];
   assign live_w[`CRR_W_REPLY] =
      {instr_reply_q, freq_reply_q};
   assign live_w[`CRR_W_RDATA] = instr_data_q;
   assign live_w[5'h04] = monitor_request_bit ? mon_val[2] :
                          rep_q[5'h04];
   assign live_w[5'h05] = monitor_request_bit ? mon_val[3] :
                          rep_q[5'h05];
   assign live_w[5'h06] = monitor_request_bit ? mon_val[4] :
                          rep_q[5'h06];
   assign live_w[5'h07] = monitor_request_bit ? mon_val[5] :
                          rep_q[5'h07];
   assign live_w[`CRR_W_FLT_CODE] = {flt_no, flt_code};
   assign live_w[`CRR_W_FLT_FREQ] = flt_hit ?
                                    flt_freq_tab[flt_idx] : 16'h0000;
   assign live_w[`CRR_W_FLT_CUR]  = flt_hit ?
                                    flt_cur_tab[flt_idx] : 16'h0000;
   assign live_w[`CRR_W_FLT_VOLT] = flt_hit ?
                                    flt_volt_tab[flt_idx] : 16'h0000;
   assign live_w[`CRR_W_FLT_TIME] = flt_hit ?
                                    flt_time_tab[flt_idx] : 16'h0000;
   assign live_w[5'h0d] = 16'h0000;
   assign live_w[5'h0e] = 16'h0000;
   assign live_w[5'h0f] = 16'h0000;

   // Even words carry slot reply codes, odd words the slot read data
   generate
      for (g = 0; g < `CRR_NUM_SLOTS; g++) begin : g_slot
         assign live_w[`CRR_W_SLOT0 + 2*g] =
            slot_reply_q[16*g +: 16];
         assign live_w[`CRR_W_SLOT0 + 2*g + 1] = slot_data_q[16*g +: 16];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Cyclic snapshot

   // Master sees a coherent set: all words move together on the tick
   generate
      for (g = 0; g < `CRR_NUM_WORDS; g++) begin : g_word
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               rep_q[g] <= `CRR_WORD_RST;
            end else if (cyc_tick && layout_ok) begin
               rep_q[g] <= live_w[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Core tables

   // Tables hold no reset; the core fills them before reporting
   always_ff @(posedge core_clk) begin
      if (mon_wr) begin
         mon_tab[mon_wr_item] <= mon_wr_value;
      end
      if (flt_wr) begin
         flt_code_tab[flt_wp_q] <= flt_wr_code;
         flt_freq_tab[flt_wp_q] <= flt_wr_freq;
         flt_cur_tab[flt_wp_q]  <= flt_wr_cur;
         flt_volt_tab[flt_wp_q] <= flt_wr_volt;
         flt_time_tab[flt_wp_q] <= flt_wr_time;
      end
   end

   // Only the valid bits reset; the tables stay plain memories
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mon_vld_q <= 256'h0;
      end else if (mon_wr) begin
         mon_vld_q[mon_wr_item] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flt_wp_q  <= 3'h0;
         flt_vld_q <= 8'h00;
      end else if (flt_wr) begin
         flt_wp_q            <= flt_wp_q + 3'h1;
         flt_vld_q[flt_wp_q] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Frequency write reply

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fstb_prev_q  <= 1'b0;
         freq_start   <= 1'b0;
         freq_reply_q <= 8'h00;
      end else begin
         fstb_prev_q <= fstb;
         freq_start  <= fstb_rise;
         if (freq_done) begin
            freq_reply_q <= freq_reply_code;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Instruction sequence

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         CRR_IDLE: begin
            if (exec_rise) begin
               st_d = CRR_BUSY;
            end
         end
         CRR_BUSY: begin
            if (instr_done) begin
               st_d = CRR_DONE;
            end
         end
         CRR_DONE: begin
            // Master drops execute to acknowledge the reply
            if (!instruction_execute_bit) begin
               st_d = CRR_IDLE;
            end
         end
      endcase
   end

   wire instr_fin = (st_q == CRR_BUSY) && instr_done;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q                  <= CRR_IDLE;
         exec_prev_q           <= 1'b0;
         instr_start           <= 1'b0;
         instruction_done_flag <= 1'b0;
      end else begin
         st_q                  <= st_d;
         exec_prev_q           <= instruction_execute_bit;
         instr_start           <= (st_q == CRR_IDLE) && exec_rise;
         instruction_done_flag <= (st_d == CRR_DONE);
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         instr_reply_q <= 8'h00;
         instr_data_q  <= 16'h0000;
         slot_reply_q  <= 80'h0;
         slot_data_q   <= 80'h0;
      end else if (instr_fin) begin
         instr_reply_q <= instr_reply_code;
         slot_reply_q  <= slot_reply_codes;
         slot_data_q   <= slot_read_data;
         // Read data is only meaningful on a normal reply
         instr_data_q  <= (instr_reply_code == 8'h00) ?
                          instr_read_data : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupts and register port

   wire [2:0] ev = {flt_wr, freq_done, instr_fin};

   // A new event in the clearing read survives the clear
   assign stat_d = (stat_q & ~{3{clr_stat}}) | ev;

   // Reply words read as zero while another layout is selected
   wire crr_word_t rd_mux = (rd_word && layout_ok) ? rep_q[reg_addr] :
                            rd_mask ? {13'h0, mask_q} :
                            rd_stat ? {13'h0, stat_q} : 16'h0000;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q      <= `CRR_MASK_RST;
         stat_q      <= 3'h0;
         irq         <= 1'b0;
         reg_rd_data <= 16'h0000;
      end else begin
         if (wr_mask) begin
            mask_q <= reg_wr_data[2:0];
         end
         stat_q      <= stat_d;
         irq         <= |(stat_d & mask_q);
         reg_rd_data <= reg_rd ? rd_mux : 16'h0000;
      end
   end

endmodule

// file: crr_params.svh
// Offsets, field positions, reset values and codes of the reply register map
`ifndef CRR_PARAMS_SVH
`define CRR_PARAMS_SVH

// Reply word indices
`define CRR_W_MON1        5'h00
`define CRR_W_MON2        5'h01
`define CRR_W_REPLY       5'h02
`define CRR_W_RDATA       5'h03
`define CRR_W_MON3        5'h04
`define CRR_W_FLT_CODE    5'h08
`define CRR_W_FLT_FREQ    5'h09
`define CRR_W_FLT_CUR     5'h0a
`define CRR_W_FLT_VOLT    5'h0b
`define CRR_W_FLT_TIME    5'h0c
`define CRR_W_SLOT0       5'h10
`define CRR_W_LAST        5'h19
`define CRR_NUM_WORDS     26

// Interrupt registers
`define CRR_A_IRQ_MASK    5'h1c
`define CRR_A_IRQ_STAT    5'h1d

// Interrupt status bits
`define CRR_IRQ_INSTR     0
`define CRR_IRQ_FREQ      1
`define CRR_IRQ_FAULT     2
`define CRR_IRQ_W         3

// Layout select values that enable this map
`define CRR_LAYOUT_A      16'h0000
`define CRR_LAYOUT_B      16'h0001
`define CRR_LAYOUT_C      16'h000c
`define CRR_LAYOUT_D      16'h000e
`define CRR_LAYOUT_E      16'h0012

// Sizes and reset values
`define CRR_FLT_DEPTH     8
`define CRR_NUM_SLOTS     5
`define CRR_WORD_RST      16'h0000
`define CRR_MASK_RST      3'h0

`endif

// file: crr_pkg.sv
// Types shared by the reply register map
package crr_pkg;
   typedef logic [15:0] crr_word_t;
   typedef logic [7:0]  crr_byte_t;
   typedef logic [4:0]  crr_addr_t;
   typedef enum logic [2:0] {
      CRR_IDLE = 3'b001,
      CRR_BUSY = 3'b010,
      CRR_DONE = 3'b100
   } crr_instr_state_t;
endpackage

// file: crr_monitor.sv
// Concurrent checks on the reply register map ports
module crr_monitor (
   // Clock and reset
   input wire logic               core_clk,
   input wire logic               rst_b,
   // Command handshakes
   input wire logic               instruction_execute_bit,
   input wire logic               instruction_done_flag,
   input wire logic               instr_start,
   input wire logic               instr_done,
   input wire logic               freq_write_ram_strobe,
   input wire logic               freq_write_eeprom_strobe,
   input wire logic               freq_start,
   // Register port
   input wire crr_pkg::crr_addr_t reg_addr,
   input wire logic               reg_rd,
   input wire crr_pkg::crr_word_t reg_rd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import crr_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////
   sequence s_wr_rise;
      $rose(freq_write_ram_strobe) || $rose(freq_write_eeprom_strobe);
   endsequence
   sequence s_flag_up;
      !instruction_done_flag ##1 instruction_done_flag;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   chk_rd_quiet:
      assert property (!reg_rd |=> reg_rd_data == 16'h0000)
      else $error("read data not idle");
   chk_hole_zero:
      assert property (reg_rd && reg_addr inside {5'h0d, 5'h0e, 5'h0f}
         |=> reg_rd_data == 16'h0000) else $error("gap word not zero");
   chk_instr_go:
      assert property (instr_start |-> $past(instruction_execute_bit)
         && !$past(instruction_execute_bit, 2))
      else $error("instruction start without execute rise");
   chk_flag_set:
      assert property (instr_done && instruction_execute_bit
         |=> instruction_done_flag) else $error("done flag missing");
   chk_flag_cause:
      assert property (s_flag_up |-> $past(instr_done))
      else $error("done flag without completion");
   chk_flag_hold:
      assert property (instruction_done_flag && instruction_execute_bit
         |=> instruction_done_flag) else $error("done flag dropped");
   chk_flag_drop:
      assert property (!instruction_execute_bit |=> !instruction_done_flag)
      else $error("done flag stays after execute low");
   chk_freq_go:
      assert property (s_wr_rise |=> freq_start)
      else $error("frequency write not started");
endmodule
////////////////////////////////////////////////////////////////////////////
bind crr_reply_regs crr_monitor u_mon (
   .core_clk(core_clk), .rst_b(rst_b),
   .instruction_execute_bit(instruction_execute_bit),
   .instruction_done_flag(instruction_done_flag),
   .instr_start(instr_start), .instr_done(instr_done),
   .freq_write_ram_strobe(freq_write_ram_strobe),
   .freq_write_eeprom_strobe(freq_write_eeprom_strobe),
   .freq_start(freq_start), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rd_data(reg_rd_data));

// file: crr_core_model.sv
// Drive core model answering frequency and instruction commands
module crr_core_model #(
   parameter int DLY = 3
) (
   // Clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   // Frequency command
   input  wire logic          freq_start,
   output logic               freq_done,
   output crr_pkg::crr_byte_t freq_reply_code,
   // Instruction command
   input  wire logic          instr_start,
   output logic               instr_done,
   output crr_pkg::crr_byte_t instr_reply_code,
   output crr_pkg::crr_word_t instr_read_data,
   output logic [79:0]        slot_reply_codes,
   output logic [79:0]        slot_read_data
);
   timeunit 1ns;
   timeprecision 1ps;
   import crr_pkg::*;
   localparam logic [79:0] SC = {16'h0004, 16'h0003, 16'h0002, 16'h0001,
                                 16'h0000};
   localparam logic [79:0] SD = {16'h00a4, 16'h00a3, 16'h00a2, 16'h00a1,
                                 16'h00a0};
   int   fc_q;
   int   ic_q;
   logic odd_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fc_q  <= 0;
         ic_q  <= 0;
         odd_q <= 1'b0;
      end else begin
         fc_q <= freq_start ? DLY : (fc_q > 0 ? fc_q - 1 : 0);
         ic_q <= instr_start ? DLY : (ic_q > 0 ? ic_q - 1 : 0);
         if (ic_q == 1) odd_q <= !odd_q;
      end
   end
   // Answers valid only beside done; inverted otherwise (instruction reply code reads ff) to expose stale use
   assign freq_done        = (fc_q == 1);
   assign instr_done       = (ic_q == 1);
   assign freq_reply_code  = freq_done ? 8'h5a : 8'ha5;
   assign instr_reply_code = instr_done ? (odd_q ? 8'h03 : 8'h00) : 8'hff;
   assign instr_read_data  = instr_done ? 16'h1234 : 16'hedcb;
   assign slot_reply_codes = instr_done ? SC : ~SC;
   assign slot_read_data   = instr_done ? SD : ~SD;
endmodule

// file: crr_reply_regs_tb.sv
// Self-checking bench for the reply register map
module crr_reply_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import crr_pkg::*;
   logic        core_clk, rst_b, tick, req, ram, ee, exe, ndisp, mwr, fwr;
   logic        rd, wr, done_f, fst, fdone, ist, idone, irq;
   crr_word_t   lay, mc0, mc4, mc5, mc6, mc7, fsel, ofreq, mval, wd, rdd;
   crr_word_t   fa, fb, fc, fd, ird;
   crr_byte_t   mitem, fcode, frc, irc;
   logic [79:0] src, srd;
   crr_addr_t   adr;
   int          fails, n_checks;
   crr_word_t   lays[5] = '{16'h0000, 16'h0001, 16'h000c, 16'h000e, 16'h0012};
   crr_reply_regs dut (.core_clk(core_clk), .rst_b(rst_b), .cyc_tick(tick),
      .layout_select_param(lay), .monitor_request_bit(req),
      .freq_write_ram_strobe(ram), .freq_write_eeprom_strobe(ee),
      .instruction_execute_bit(exe), .monitor_code_word(mc0),
      .monitor_code_word_4(mc4), .monitor_code_word_5(mc5),
      .monitor_code_word_6(mc6), .monitor_code_word_7(mc7),
      .fault_record_select_word(fsel), .instruction_done_flag(done_f),
      .out_freq(ofreq), .negative_display_param(ndisp), .mon_wr(mwr),
      .mon_wr_item(mitem), .mon_wr_value(mval), .flt_wr(fwr),
      .flt_wr_code(fcode), .flt_wr_freq(fa), .flt_wr_cur(fb),
      .flt_wr_volt(fc), .flt_wr_time(fd), .freq_start(fst),
      .freq_done(fdone), .freq_reply_code(frc), .instr_start(ist),
      .instr_done(idone), .instr_reply_code(irc), .instr_read_data(ird),
      .slot_reply_codes(src), .slot_read_data(srd), .reg_addr(adr),
      .reg_wr(wr), .reg_wr_data(wd), .reg_rd(rd), .reg_rd_data(rdd),
      .irq(irq));
   crr_core_model #(.DLY(3)) u_core (.core_clk(core_clk), .rst_b(rst_b),
      .freq_start(fst), .freq_done(fdone), .freq_reply_code(frc),
      .instr_start(ist), .instr_done(idone), .instr_reply_code(irc),
      .instr_read_data(ird), .slot_reply_codes(src), .slot_read_data(srd));
   ////////////////////////////////////////////////////////////////////////
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input string nm, input crr_word_t e, input crr_word_t g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task rdc(input crr_addr_t a, input crr_word_t e);
      @(posedge core_clk) begin adr <= a; rd <= 1'b1; end
      @(posedge core_clk) rd <= 1'b0;
      #1 chk($sformatf("word %h", a), e, rdd);
   endtask
   task wrr(input crr_addr_t a, input crr_word_t d);
      @(posedge core_clk) begin adr <= a; wd <= d; wr <= 1'b1; end
      @(posedge core_clk) wr <= 1'b0;
   endtask
   task cyc;
      @(posedge core_clk) tick <= 1'b1;
      @(posedge core_clk) tick <= 1'b0;
   endtask
   task mw(input crr_byte_t i, input crr_word_t v);
      @(posedge core_clk) begin mwr <= 1'b1; mitem <= i; mval <= v; end
      @(posedge core_clk) mwr <= 1'b0;
   endtask
   task fpush(input crr_byte_t c, input crr_word_t f);
      @(posedge core_clk) begin
         fwr <= 1'b1; fcode <= c; fa <= f; fb <= f + 16'h0001;
         fc <= f + 16'h0002;
         fd <= f + 16'h0003;
      end
      @(posedge core_clk) fwr <= 1'b0;
   endtask
   task fw(input int s);
      @(posedge core_clk) if (s == 1) ee <= 1'b1; else ram <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(posedge core_clk);
         #1;
         if (fdone === 1'b1) break;
      end
      chk("freq done", 16'h0001, {15'h0, fdone});
      @(posedge core_clk) begin ram <= 1'b0; ee <= 1'b0; end
   endtask
   task ins(input crr_word_t w2, input crr_word_t w3);
      @(posedge core_clk) exe <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge core_clk);
         #1;
         if (done_f === 1'b1) break;
      end
      chk("done flag", 16'h0001, {15'h0, done_f});
      chk("irq high", 16'h0001, {15'h0, irq});
      cyc;
      rdc(5'h02, w2);
      rdc(5'h03, w3);
      rdc(5'h1d, 16'h0001);
      @(posedge core_clk) exe <= 1'b0;
      #1 chk("irq low", 16'h0000, {15'h0, irq});
      @(posedge core_clk);
      #1 chk("flag low", 16'h0000, {15'h0, done_f});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      close_out;
   end
   initial begin
      {rst_b, tick, req, ram, ee, exe, ndisp, mwr, fwr, rd, wr} = '0;
      {mc0, mc4, mc5, mc6, mc7, fsel, mval, wd, fa, fb, fc, fd} = '0;
      {mitem, fcode, adr} = '0;
      lay = 16'h0002;
      ofreq = 16'h0bb8;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      rdc(5'h1c, 16'h0000);
      cyc;
      rdc(5'h01, 16'h0000);
      foreach (lays[i]) begin
         @(posedge core_clk) begin
            lay <= lays[i];
            ofreq <= crr_word_t'(16'h0100 + i);
         end
         cyc;
         rdc(5'h01, crr_word_t'(16'h0100 + i));
      end
      mw(8'h03, 16'h0111);
      mw(8'h05, 16'h0222);
      mw(8'h07, 16'hfff0);
      @(posedge core_clk) begin
         req <= 1'b1; mc0 <= 16'h0503; mc4 <= 16'h0003; mc5 <= 16'h0005;
         mc6 <= 16'h0007; mc7 <= 16'h0503;
      end
      cyc;
      rdc(5'h00, 16'h0111);
      rdc(5'h01, 16'h0222);
      rdc(5'h04, 16'h0111);
      rdc(5'h05, 16'h0222);
      rdc(5'h06, 16'h0010);
      rdc(5'h07, 16'h0111);
      @(posedge core_clk) begin ndisp <= 1'b1; mc5 <= 16'h0009; end
      cyc;
      rdc(5'h06, 16'hfff0);
      rdc(5'h05, 16'h0000);
      wrr(5'h00, 16'hffff);
      rdc(5'h00, 16'h0111);
      rdc(5'h0d, 16'h0000);
      fpush(8'h21, 16'h1000);
      fpush(8'h22, 16'h2000);
      cyc;
      rdc(5'h08, 16'h0022);
      for (int k = 0; k < 4; k++)
         rdc(crr_addr_t'(9 + k), crr_word_t'(16'h2000 + k));
      @(posedge core_clk) fsel <= 16'h0001;
      cyc;
      rdc(5'h08, 16'h0121);
      rdc(5'h09, 16'h1000);
      @(posedge core_clk) fsel <= 16'h0002;
      cyc;
      rdc(5'h08, 16'h0200);
      rdc(5'h0c, 16'h0000);
      for (int s = 0; s < 2; s++) begin
         fw(s);
         cyc;
         rdc(5'h02, 16'h005a);
      end
      rdc(5'h1d, 16'h0006);
      wrr(5'h1c, 16'h0001);
      rdc(5'h1c, 16'h0001);
      ins(16'h005a, 16'h1234);
      for (int k = 0; k < 5; k++)
         rdc(crr_addr_t'(16 + 2 * k), crr_word_t'(k));
      rdc(5'h11, 16'h00a0);
      ins(16'h035a, 16'h0000);
      close_out;
   end
endmodule
